// *** shared/cbc_regs.svh ***
// Function
// RULE1: Enabled filter counts selected clock cycles after an edge, then clears itself.
// RULE2: After the delay, a pulse is given only if the level has flipped.
// RULE3: Delay select 00 bypass, 01 256, 10 512, 11 1024 cycles.
// RULE4: The source keeps active edges further apart than the filter delay.
// RULE5: Capture empty once read or moved; holding empty once read.
// RULE6: With no-overwrite set, events write capture or holding only when empty.
// RULE7: System control register takes one write in normal mode, any in special.
// RULE8: A share bit makes channel x's input drive channel y too.
// RULE9: Queue, flag mode, no-overwrite: first event captures, second moves, recaptures, flags.
// RULE10: Flag mode 0 flags every capture; mode 1 in queue flags only holding loads.
// RULE11: Accumulator wraps from all ones unless saturate is set, then holds.
// RULE12: Buffer enable clear disables holding registers and both buffer modes.
// RULE13: Force latch write in latch mode latches captures and accumulators at once.
// RULE14: Queue mode captures the timer; next capture first moves old value to holding.
// RULE15: Latch mode copies on modulus zero or zero write, then clears accumulators.
// RULE16: Test register reads any time, writes only in special mode.
// RULE17: Divider bypass splits the counter into two directly clocked bytes; high overflow flags.
// RULE18: Port read gives pin level for inputs and latch for outputs.
// RULE19: Port writes go to a latch driving the pin only as a general output.
// RULE20: Pin 7 feeds the accumulator only with compare-7 action and mask bits zero.
// RULE21: Compare 7 may still reset the counter while pin 7 feeds the accumulator.
// RULE22: The source makes input pulses wider than two clock periods.
// RULE23: Each port input passes two clock flip-flops before edge logic.
// RULE24: Overwrite control holds one no-overwrite bit per channel, bit equals channel.
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH
`define CBC_IDX_DLY 8'ha9
`define CBC_IDX_COVW 8'haa
`define CBC_IDX_SYS 8'hab
`define CBC_IDX_TST 8'had
`define CBC_IDX_PORT 8'hae
`define CBC_IDX_FLAGS 8'hc0
`define CBC_IDX_OVF 8'hc1
`define CBC_IDX_CNT 8'hc2
`define CBC_IDX_FORCE 8'hc3
`define CBC_IDX_CAP 8'hc4
`define CBC_IDX_HOLD 8'hcc
`define CBC_IDX_ACC 8'hd0
`define CBC_RST_DLY 2'h0
`define CBC_RST_COVW 8'h00
`define CBC_RST_SYS 8'h00
`define CBC_RST_TST 1'h0
`define CBC_RST_PORT 8'h00
`define CBC_BIT_BYP 1
`define CBC_BIT_TOF 7
`define CBC_BIT_FORCE 0
`define CBC_DLY_SEL1 11'h100
`define CBC_DLY_SEL2 11'h200
`define CBC_DLY_SEL3 11'h400
`endif

// *** shared/cbc_pkg.sv ***
package cbc_pkg;
  typedef struct packed {
    logic [3:0] share;
    logic flag_setting_select;
    logic accumulator_saturate;
    logic holding_buffer_enable;
    logic latch_or_queue_select;
  } cbc_sys_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cbc_wb_req_t;

  typedef struct packed {
    logic [7:0] ddr;
    logic [7:0] oc_ctl;
    logic om7;
    logic ol7;
    logic compare7_mask_pin7;
    logic oc7_reset;
    logic mc_zero;
    logic mc_zero_wr;
  } cbc_tmr_t;
endpackage : cbc_pkg

// *** rtl/cbc_edge_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cbc_regs.svh"
module cbc_edge_filter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronised level and delay choice
  input wire logic level_i,
  input wire logic [1:0] sel_i,
  // Accepted edge
  output logic pulse_o
);
  logic last;
  logic ref_lvl;
  logic busy;
  logic [10:0] cnt;
  logic [10:0] lim;

  // RULE3 delay decode
  always_comb begin
    unique case (sel_i)
      2'h1: lim = `CBC_DLY_SEL1;
      2'h2: lim = `CBC_DLY_SEL2;
      2'h3: lim = `CBC_DLY_SEL3;
      default: lim = 11'h000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last <= 1'b0;
      ref_lvl <= 1'b0;
      busy <= 1'b0;
      cnt <= 11'h000;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (!busy) begin
        last <= level_i;
        if (level_i != last) begin
          if (sel_i == 2'h0) begin
            pulse_o <= 1'b1;
          end else begin
            // RULE1 start count
            busy <= 1'b1;
            ref_lvl <= last;
            cnt <= 11'h001;
          end
        end
      end else if (cnt == lim) begin
        // RULE1 auto clear
        busy <= 1'b0;
        cnt <= 11'h000;
        last <= level_i;
        // RULE2 narrow pulse reject
        pulse_o <= (level_i != ref_lvl);
      end else begin
        cnt <= cnt + 11'h001;
      end
    end
  end
endmodule : cbc_edge_filter
`default_nettype wire

// *** rtl/cbc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cbc_regs.svh"
module cbc_top #(
  parameter int NCH = 8,
  parameter int NBUF = 4,
  parameter int PRESC = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire cbc_pkg::cbc_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer side controls, same clock
  input wire cbc_pkg::cbc_tmr_t tmr_i,
  input wire logic special_mode_i,
  // Timer port pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  // Status to the timer
  output logic pa_input_o,
  output logic [7:0] capture_flags_o,
  output logic counter_overflow_flag_o
);
  import cbc_pkg::*;

  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] ev;
  logic [7:0] eff;
  logic [1:0] dly_sel;
  logic [7:0] no_overwrite_bit;
  cbc_sys_t sys;
  logic sys_written;
  logic divider_bypass;
  logic [7:0] port_latch;
  logic [15:0] cap [NCH];
  logic [NCH-1:0] cap_full;
  logic [15:0] hold [NBUF];
  logic [NBUF-1:0] hold_full;
  logic [7:0] acc [NBUF];
  logic [7:0] acc_hold [NBUF];
  logic [7:0] cflag;
  logic counter_overflow_flag;
  logic [15:0] free_running_count;
  logic [7:0] presc;
  logic [7:0] idx;
  logic take;
  logic wr;
  logic rd;
  logic latch_ev;
  logic force_wr;
  logic queue;
  logic [31:0] next_dat;
  logic [NCH-1:0] rd_cap;
  logic [NBUF-1:0] rd_hold;

  // RULE23 two-stage synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flt
      cbc_edge_filter u_flt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(sync2[g]),
        .sel_i(dly_sel),
        .pulse_o(ev[g])
      );
    end
  endgenerate

  // RULE8 share pairs 0-4 .. 3-7
  always_comb begin
    eff[3:0] = ev[3:0];
    for (int k = 0; k < 4; k++) begin
      eff[k+4] = sys.share[k] ? ev[k] : ev[k+4];
    end
  end

  // Bus decode; actions happen on the edge that raises ack
  assign idx = wb_i.adr[9:2];
  assign take = wb_i.cyc && wb_i.stb && !wb_ack_o;
  assign wr = take && wb_i.we && wb_i.sel[0];
  assign rd = take && !wb_i.we;
  assign force_wr = wr && (idx == `CBC_IDX_FORCE) && wb_i.dat[`CBC_BIT_FORCE];
  // RULE12 modes only with buffers on
  assign queue = sys.holding_buffer_enable && !sys.latch_or_queue_select;
  // RULE13 RULE15 latch sources
  assign latch_ev = sys.holding_buffer_enable && sys.latch_or_queue_select && (tmr_i.mc_zero || tmr_i.mc_zero_wr || force_wr);

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      rd_cap[n] = rd && (idx == `CBC_IDX_CAP + 8'(n));
    end
    for (int n = 0; n < NBUF; n++) begin
      rd_hold[n] = rd && (idx == `CBC_IDX_HOLD + 8'(n));
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (idx)
      `CBC_IDX_DLY: next_dat[1:0] = dly_sel;
      `CBC_IDX_COVW: next_dat[7:0] = no_overwrite_bit;
      `CBC_IDX_SYS: next_dat[7:0] = sys;
      `CBC_IDX_TST: next_dat[`CBC_BIT_BYP] = divider_bypass;
      // RULE18 pin or latch readback
      `CBC_IDX_PORT: next_dat[7:0] = (tmr_i.ddr & port_latch) | (~tmr_i.ddr & sync2);
      `CBC_IDX_FLAGS: next_dat[7:0] = cflag;
      `CBC_IDX_OVF: next_dat[`CBC_BIT_TOF] = counter_overflow_flag;
      `CBC_IDX_CNT: next_dat[15:0] = free_running_count;
      default: begin
        for (int n = 0; n < NCH; n++) begin
          if (idx == `CBC_IDX_CAP + 8'(n)) begin
            next_dat[15:0] = cap[n];
          end
        end
        for (int n = 0; n < NBUF; n++) begin
          if (idx == `CBC_IDX_HOLD + 8'(n)) begin
            next_dat[15:0] = hold[n];
          end
          if (idx == `CBC_IDX_ACC + 8'(n)) begin
            next_dat[15:0] = {acc_hold[n], acc[n]};
          end
        end
      end
    endcase
  end

  // Every access answers one cycle later, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= take;
      if (rd) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_sel <= `CBC_RST_DLY;
      no_overwrite_bit <= `CBC_RST_COVW;
      sys <= `CBC_RST_SYS;
      sys_written <= 1'b0;
      divider_bypass <= `CBC_RST_TST;
      port_latch <= `CBC_RST_PORT;
    end else if (wr) begin
      if (idx == `CBC_IDX_DLY) begin
        dly_sel <= wb_i.dat[1:0];
      end
      // RULE24 one bit per channel
      if (idx == `CBC_IDX_COVW) begin
        no_overwrite_bit <= wb_i.dat[7:0];
      end
      // RULE7 write once when normal
      if (idx == `CBC_IDX_SYS && (special_mode_i || !sys_written)) begin
        sys <= wb_i.dat[7:0];
        sys_written <= 1'b1;
      end
      // RULE16 special mode only
      if (idx == `CBC_IDX_TST && special_mode_i) begin
        divider_bypass <= wb_i.dat[`CBC_BIT_BYP];
      end
      // RULE19 latch only
      if (idx == `CBC_IDX_PORT) begin
        port_latch <= wb_i.dat[7:0];
      end
    end
  end

  // Pins: driven only as general output, not under timer control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
      pa_input_o <= 1'b0;
    end else begin
      // RULE19 general output only
      pin_o <= port_latch;
      pin_oe_o <= tmr_i.ddr & ~tmr_i.oc_ctl;
      // RULE20 independent pin 7 path
      pa_input_o <= !tmr_i.om7 && !tmr_i.ol7 && !tmr_i.compare7_mask_pin7 && sync2[7];
    end
  end

  // Capture, holding and flags; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < NCH; n++) begin
        cap[n] <= 16'h0000;
      end
      for (int n = 0; n < NBUF; n++) begin
        hold[n] <= 16'h0000;
      end
      cap_full <= '0;
      hold_full <= '0;
      cflag <= 8'h00;
    end else begin
      if (wr && idx == `CBC_IDX_FLAGS) begin
        cflag <= cflag & ~wb_i.dat[7:0];
      end
      for (int n = 0; n < NCH; n++) begin
        // RULE5 read empties
        if (rd_cap[n]) begin
          cap_full[n] <= 1'b0;
        end
        if (n < NBUF) begin
          if (rd_hold[n]) begin
            hold_full[n] <= 1'b0;
          end
          // RULE15 latch into holding
          if (latch_ev && !(no_overwrite_bit[n] && hold_full[n])) begin
            hold[n] <= cap[n];
            hold_full[n] <= 1'b1;
            // RULE5 moved means empty
            cap_full[n] <= 1'b0;
          end
        end
        if (eff[n]) begin
          if (n < NBUF && queue) begin
            // RULE14 RULE9 queue shift
            if (cap_full[n] && !(no_overwrite_bit[n] && hold_full[n])) begin
              hold[n] <= cap[n];
              hold_full[n] <= 1'b1;
              cap[n] <= free_running_count;
              cap_full[n] <= 1'b1;
              cflag[n] <= 1'b1;
            // RULE6 blocked when full
            end else if (!no_overwrite_bit[n] || !cap_full[n]) begin
              cap[n] <= free_running_count;
              cap_full[n] <= 1'b1;
              // RULE10 flag mode choice
              if (!sys.flag_setting_select) begin
                cflag[n] <= 1'b1;
              end
            end else if (!sys.flag_setting_select) begin
              cflag[n] <= 1'b1;
            end
          end else begin
            // RULE6 no overwrite
            if (!no_overwrite_bit[n] || !cap_full[n]) begin
              cap[n] <= free_running_count;
              cap_full[n] <= 1'b1;
            end
            // RULE10 flag each edge
            cflag[n] <= 1'b1;
          end
        end
      end
    end
  end

  // Pulse accumulators
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < NBUF; n++) begin
        acc[n] <= 8'h00;
        acc_hold[n] <= 8'h00;
      end
    end else begin
      for (int n = 0; n < NBUF; n++) begin
        if (latch_ev) begin
          // RULE13 RULE15 copy then clear
          acc_hold[n] <= acc[n];
          acc[n] <= 8'h00;
        end else if (eff[n]) begin
          // RULE11 wrap or saturate
          if (!(sys.accumulator_saturate && acc[n] == 8'hff)) begin
            acc[n] <= acc[n] + 8'h01;
          end
        end
      end
    end
  end

  // Free-running counter; prescaler is a plain divider enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      free_running_count <= 16'h0000;
      presc <= 8'h00;
      counter_overflow_flag <= 1'b0;
    end else begin
      if (wr && idx == `CBC_IDX_OVF && wb_i.dat[`CBC_BIT_TOF]) begin
        counter_overflow_flag <= 1'b0;
      end
      if (tmr_i.oc7_reset) begin
        // RULE21 compare 7 reset kept
        free_running_count <= 16'h0000;
        presc <= 8'h00;
      end else if (divider_bypass) begin
        // RULE17 two bytes, direct clock
        free_running_count[15:8] <= free_running_count[15:8] + 8'h01;
        free_running_count[7:0] <= free_running_count[7:0] + 8'h01;
        if (free_running_count[15:8] == 8'hff) begin
          counter_overflow_flag <= 1'b1;
        end
      end else if (presc == 8'(PRESC - 1)) begin
        presc <= 8'h00;
        free_running_count <= free_running_count + 16'h0001;
        if (free_running_count == 16'hffff) begin
          counter_overflow_flag <= 1'b1;
        end
      end else begin
        presc <= presc + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_flags_o <= 8'h00;
      counter_overflow_flag_o <= 1'b0;
    end else begin
      capture_flags_o <= cflag;
      counter_overflow_flag_o <= counter_overflow_flag;
    end
  end
endmodule : cbc_top
`default_nettype wire

// *** dv/cbc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbc_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire cbc_pkg::cbc_wb_req_t wb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Timer side
  input wire cbc_pkg::cbc_tmr_t tmr_i,
  input wire logic special_mode_i,
  // Pins and status
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic pa_input_o,
  input wire logic [7:0] capture_flags_o,
  input wire logic counter_overflow_flag_o
);
  import cbc_pkg::*;
  logic [2:0] up;
  logic pa_free;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Sync history means nothing until reset has drained
  always_ff @(posedge clk_i) begin
    if (rst_i) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  assign pa_free = !(tmr_i.om7 || tmr_i.ol7 || tmr_i.compare7_mask_pin7);
  sequence s_take;
    wb_i.cyc && wb_i.stb && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (s_take |=> s_answer)
    else $error("ack not one pulse");
  a_ack_unasked: assert property (!(wb_i.cyc && wb_i.stb) |=> !wb_ack_o)
    else $error("ack unasked");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper data set");
  a_oe_direction: assert property (up != 3'h0 |-> pin_oe_o == ($past(tmr_i.ddr) & ~$past(tmr_i.oc_ctl)))
    else $error("enable wrong");
  a_pa_blocked: assert property (!pa_free |=> !pa_input_o)
    else $error("pa not blocked");
  a_pa_sync: assert property (up == 3'h7 && $past(pa_free) |-> pa_input_o == $past(pin_i[7], 3))
    else $error("pa sync depth");
  a_flag_clear: assert property (!$past(rst_i) && |($past(capture_flags_o) & ~capture_flags_o) |->
    $past(wb_ack_o) && $past(wb_i.we)) else $error("flag lost");
  a_ovf_clear: assert property (!$past(rst_i) && $fell(counter_overflow_flag_o) |->
    $past(wb_ack_o) && $past(wb_i.we)) else $error("overflow lost");
endmodule : cbc_properties
bind cbc_top cbc_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tmr_i(tmr_i), .special_mode_i(special_mode_i), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .pa_input_o(pa_input_o), .capture_flags_o(capture_flags_o),
  .counter_overflow_flag_o(counter_overflow_flag_o));
`default_nettype wire

// *** dv/cbc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbc_pin_model (
  // Clock
  input wire logic clk_i,
  // Commanded levels and deliberate spikes
  input wire logic [7:0] lvl_i,
  input wire logic [7:0] spike_i,
  // Pin drive
  output logic [7:0] pin_o
);
  always_ff @(posedge clk_i) begin
    pin_o <= lvl_i ^ spike_i;
  end
endmodule : cbc_pin_model
`default_nettype wire

// *** dv/cbc_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbc_top_bench;
  import cbc_pkg::*;
  logic clk_i, rst_i, special_mode_i, wb_ack_o, pa_input_o, counter_overflow_flag_o;
  cbc_wb_req_t wb_i;
  cbc_tmr_t tmr_i;
  logic [31:0] wb_dat_o, q, r2;
  logic [7:0] lvl, spk, mdl, pin, pin_o, pin_oe_o, capture_flags_o;
  logic [15:0] rnd;
  logic [32:0] e;
  logic [32:0] exq[$];
  logic [7:0] ridx[7] = '{8'ha9, 8'haa, 8'hab, 8'had, 8'hae, 8'hc0, 8'he0};
  logic [7:0] eidx[4] = '{8'hc4, 8'hc7, 8'hcc, 8'hcf};
  int n_fail, checks, cyc_n, lat[4];

  cbc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tmr_i(tmr_i), .special_mode_i(special_mode_i), .pin_i(pin), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pa_input_o(pa_input_o), .capture_flags_o(capture_flags_o), .counter_overflow_flag_o(counter_overflow_flag_o));
  cbc_pin_model far (.clk_i(clk_i), .lvl_i(lvl), .spike_i(spk), .pin_o(mdl));
  // Wire level: driven pins win over the far side
  assign pin = (pin_oe_o & pin_o) | (~pin_oe_o & mdl);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic cmp(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : cmp
  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic x, output logic [31:0] v);
    if (!w) exq.push_back({x, d});
    wb_i <= '{1'b1, 1'b1, w, {a, 2'h0}, 4'hf, w ? d : 32'h0};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    v = wb_dat_o;
    wb_i.cyc <= 1'b0;
    wb_i.stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 1'b1, q);
  endtask : rd
  // Edges spaced wider than two clocks and any delay in use
  task automatic tog(input logic [7:0] m, input int n);
    repeat (n) begin
      lvl <= lvl ^ m;
      repeat (5) @(posedge clk_i);
    end
  endtask : tog
  task automatic lat_of(input int s);
    wr(8'ha9, s);
    wr(8'hc0, 32'hff);
    lvl <= lvl ^ 8'h20;
    lat[s] = 0;
    while (capture_flags_o[5] !== 1'b1 && lat[s] < 3000) begin
      @(posedge clk_i);
      lat[s]++;
    end
  endtask : lat_of

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_i.we === 1'b0) begin
      e = exq.pop_front();
      if (e[32]) cmp(wb_dat_o, e[31:0]);
    end
    cyc_n++;
    if (cyc_n == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    rst_i = 1'b1;
    wb_i = '0;
    tmr_i = '0;
    special_mode_i = 1'b0;
    lvl = 8'h00;
    spk = 8'h00;
    rnd = 16'h6adf;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    foreach (ridx[k]) rd(ridx[k], 32'h0);
    wr(8'hab, 32'h02);
    wr(8'hab, 32'h0f);
    rd(8'hab, 32'h02);
    wr(8'had, 32'h02);
    rd(8'had, 32'h00);
    special_mode_i <= 1'b1;
    wr(8'had, 32'h02);
    rd(8'had, 32'h02);
    repeat (300) @(posedge clk_i);
    cmp({31'h0, counter_overflow_flag_o}, 32'h1);
    wr(8'had, 32'h00);
    wr(8'hc1, 32'h80);
    repeat (2) @(posedge clk_i);
    cmp({31'h0, counter_overflow_flag_o}, 32'h0);
    wr(8'hab, 32'h02);
    tog(8'h01, 1);
    repeat (40) @(posedge clk_i);
    tog(8'h01, 1);
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'hcc, 32'h0, 1'b0, r2);
    bus(1'b0, 8'hc4, 32'h0, 1'b0, q);
    cmp({16'h0, q[15:0] - r2[15:0]}, 32'h2d);
    cmp({24'h0, capture_flags_o}, 32'h01);
    wr(8'hab, 32'h00);
    tog(8'h02, 2);
    rd(8'hcd, 32'h0);
    wr(8'hab, 32'h03);
    wr(8'haa, 32'h04);
    tog(8'h0c, 1);
    repeat (40) @(posedge clk_i);
    tog(8'h0c, 1);
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'hc6, 32'h0, 1'b0, r2);
    bus(1'b0, 8'hc7, 32'h0, 1'b0, q);
    cmp({16'h0, q[15:0] - r2[15:0]}, 32'h2d);
    wr(8'hc3, 32'h01);
    rd(8'hd1, 32'h0200);
    tog(8'h02, 259);
    rd(8'hd1, 32'h0203);
    tmr_i.mc_zero <= 1'b1;
    @(posedge clk_i);
    tmr_i.mc_zero <= 1'b0;
    rd(8'hd1, 32'h0300);
    wr(8'hab, 32'h07);
    tog(8'h02, 260);
    rd(8'hd1, 32'h03ff);
    tmr_i.mc_zero_wr <= 1'b1;
    @(posedge clk_i);
    tmr_i.mc_zero_wr <= 1'b0;
    rd(8'hd1, 32'hff00);
    wr(8'hab, 32'h1a);
    wr(8'haa, 32'h09);
    wr(8'hc0, 32'hff);
    foreach (eidx[k]) bus(1'b0, eidx[k], 32'h0, 1'b0, q);
    tog(8'h09, 1);
    repeat (4) @(posedge clk_i);
    cmp({24'h0, capture_flags_o}, 32'h10);
    tog(8'h09, 1);
    repeat (4) @(posedge clk_i);
    cmp({24'h0, capture_flags_o}, 32'h19);
    wr(8'hab, 32'h00);
    for (int s = 1; s < 4; s++) lat_of(s);
    cmp(lat[2] - lat[1], 32'h100);
    cmp(lat[3] - lat[1], 32'h300);
    wr(8'hc0, 32'hff);
    spk <= 8'h20;
    repeat (10) @(posedge clk_i);
    spk <= 8'h00;
    repeat (1100) @(posedge clk_i);
    cmp({24'h0, capture_flags_o}, 32'h00);
    wr(8'ha9, 32'h0);
    tmr_i.ddr <= 8'h0f;
    tmr_i.oc_ctl <= 8'h03;
    repeat (4) begin
      rnd = lfsr(rnd);
      {tmr_i.om7, tmr_i.ol7, tmr_i.compare7_mask_pin7} <= rnd[2:0];
      lvl <= rnd[15:8];
      wr(8'hae, {24'h0, rnd[7:0]});
      repeat (4) @(posedge clk_i);
      rd(8'hae, {24'h0, (lvl & 8'hf0) | (rnd[7:0] & 8'h0f)});
      cmp({24'h0, pin_o}, {24'h0, rnd[7:0]});
    end
    tmr_i <= '0;
    repeat (8) @(posedge clk_i);
    // Counter restarts from zero while pin 7 feeds the accumulator
    tmr_i.oc7_reset <= 1'b1;
    @(posedge clk_i);
    tmr_i.oc7_reset <= 1'b0;
    rd(8'hc2, 32'h0);
    complete_run();
  end
endmodule : cbc_top_bench
`default_nettype wire
